/* spi_port_consts.svh */
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define SPI_IDX_CONTROL 8'h2C
`define SPI_IDX_STATUS  8'h2D
`define SPI_IDX_DATA    8'h2E

// ----------------------------------------------------------------
// status field positions and reset values
// ----------------------------------------------------------------
`define SPI_ST_DONE_POS  7
`define SPI_ST_WRITE_COLLISION_FLAG_POS  6
`define SPI_ST_X2_POS    0
`define SPI_CONTROL_RST  8'h00
`define SPI_STATUS_RST   8'h00
`define SPI_DATA_RST     8'h00

// ----------------------------------------------------------------
// sck dividers of clk_sys, normal and double speed
// ----------------------------------------------------------------
`define SPI_DIV_N0 4
`define SPI_DIV_N1 16
`define SPI_DIV_N2 64
`define SPI_DIV_N3 128
`define SPI_DIV_X0 2
`define SPI_DIV_X1 8
`define SPI_DIV_X2 32
`define SPI_DIV_X3 64
`define SPI_EDGES_PER_BYTE 16

`endif

/* spi_port_pkg.sv */
package spi_port_pkg;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       irqEnableBit;
        logic       portEnableBit;
        logic       bitOrderSelect;
        logic       masterSelectBit;
        logic       clockPolarityBit;
        logic       clockPhaseBit;
        logic [1:0] rateSelect;
    } ctrl_s;

    // the three serial pins as one bundle
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
    } pins_s;

    // master shift sequencer
    typedef enum logic {
        XFER_IDLE,
        XFER_SHIFT
    } xfer_e;

endpackage

/* spi_master_slave_port.sv */
`timescale 1ns/1ps
`include "spi_port_consts.svh"
`default_nettype none

module spi_master_slave_port (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [7:0]           avsAddress,
    input  wire logic                 avsRead,
    input  wire logic                 avsWrite,
    input  wire logic [31:0]          avsWriteData,
    input  wire logic [3:0]           avsByteEnable,
    output logic      [31:0]          avsReadData,
    output logic                      avsWaitRequest,
    input  wire logic                 globalIrqEnable,
    input  wire logic                 irqVectorTaken,
    output logic                      irqRequest,
    input  wire logic                 ssIsOutput,
    input  wire logic                 mosiDirOut,
    input  wire logic                 misoDirOut,
    input  wire logic                 sckDirOut,
    input  wire logic                 slaveSelectIn_n,
    input  wire spi_port_pkg::pins_s  pinIn,
    output spi_port_pkg::pins_s       pinOut,
    output spi_port_pkg::pins_s       pinOe
);

    localparam logic [7:0] ADDR_CONTROL = 8'(`SPI_IDX_CONTROL * 4);
    localparam logic [7:0] ADDR_STATUS  = 8'(`SPI_IDX_STATUS * 4);
    localparam logic [7:0] ADDR_DATA    = 8'(`SPI_IDX_DATA * 4);
    localparam logic [3:0] LAST_EDGE    = 4'(`SPI_EDGES_PER_BYTE - 1);
    localparam logic [10:0] BYTE_CYCLES_MAX = 11'h406;  // longest master byte plus margin

    spi_port_pkg::ctrl_s ctrlQ;
    spi_port_pkg::xfer_e stateQ;
    logic        doubleSpeedQ;
    logic        doneFlagQ;
    logic        wcolFlagQ;
    logic        clearArmQ;
    logic        waitQ;
    logic [7:0]  txShQ;
    logic [7:0]  rxShQ;
    logic [7:0]  rxBufQ;
    logic [3:0]  edgeCntQ;
    logic [5:0]  divCntQ;
    logic        sckQ;
    logic        sckPrevQ;
    logic [3:0]  syncAQ;
    logic [3:0]  syncBQ;
    logic [2:0]  mSmpQ;
    logic [2:0]  mDoneQ;
    logic [10:0] shiftCycQ;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------

    // two flops on every pin input; only the second stage is read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syncAQ <= 4'hF;
            syncBQ <= 4'hF;
        end else begin
            syncAQ <= {slaveSelectIn_n, pinIn.sck, pinIn.mosi, pinIn.miso};
            syncBQ <= syncAQ;
        end
    end

    logic ssS;
    logic sckS;
    logic mosiS;
    logic misoS;
    assign ssS   = syncBQ[3];
    assign sckS  = syncBQ[2];
    assign mosiS = syncBQ[1];
    assign misoS = syncBQ[0];

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------

    // request completes in the cycle where waitrequest is low
    logic acc;
    logic dataAcc;
    logic dataWr;
    logic ctrlWr;
    logic statWr;
    logic statRd;
    assign acc     = (avsRead || avsWrite) && !waitQ;
    assign dataAcc = acc && (avsAddress == ADDR_DATA);
    assign dataWr  = dataAcc && avsWrite && avsByteEnable[0];
    assign ctrlWr  = acc && avsWrite && avsByteEnable[0] && (avsAddress == ADDR_CONTROL);
    assign statWr  = acc && avsWrite && avsByteEnable[0] && (avsAddress == ADDR_STATUS);
    assign statRd  = acc && avsRead && (avsAddress == ADDR_STATUS);

    // ----------------------------------------------------------------
    // role, edge and completion terms
    // ----------------------------------------------------------------
    logic isMaster;
    logic slvActive;
    logic fallBack;
    logic busy;
    logic divTick;
    logic edgeStb;
    logic edgeLead;
    logic sampleEdge;
    logic setupEdge;
    logic done;
    logic rxStb;
    logic byteDone;
    logic inBit;
    logic txBit;
    logic [6:0] halfPeriod;
    logic [7:0] rxNext;

    // divider choice from rate bits and double speed
    always_comb begin
        case ({doubleSpeedQ, ctrlQ.rateSelect})
            3'h0: halfPeriod = 7'(`SPI_DIV_N0 / 2);
            3'h1: halfPeriod = 7'(`SPI_DIV_N1 / 2);
            3'h2: halfPeriod = 7'(`SPI_DIV_N2 / 2);
            3'h3: halfPeriod = 7'(`SPI_DIV_N3 / 2);
            3'h4: halfPeriod = 7'(`SPI_DIV_X0 / 2);
            3'h5: halfPeriod = 7'(`SPI_DIV_X1 / 2);
            3'h6: halfPeriod = 7'(`SPI_DIV_X2 / 2);
            default: halfPeriod = 7'(`SPI_DIV_X3 / 2);
        endcase
    end

    assign isMaster  = ctrlQ.portEnableBit && ctrlQ.masterSelectBit;
    assign fallBack  = isMaster && !ssIsOutput && !ssS;
    assign slvActive = ctrlQ.portEnableBit && !ctrlQ.masterSelectBit && !ssS;
    assign busy      = (stateQ == spi_port_pkg::XFER_SHIFT) || (mDoneQ != 3'h0)
                       || (slvActive && edgeCntQ != 4'h0);
    assign divTick   = (divCntQ == 6'(halfPeriod - 7'h01));

    // master edges come from the divider, slave edges from sampled sck
    always_comb begin
        if (isMaster) begin
            edgeStb  = (stateQ == spi_port_pkg::XFER_SHIFT) && divTick && !fallBack;
            edgeLead = (sckQ == ctrlQ.clockPolarityBit);
        end else begin
            edgeStb  = slvActive && (sckS != sckPrevQ);
            edgeLead = (sckPrevQ == ctrlQ.clockPolarityBit);
        end
    end

    // sample on one edge kind, setup on the other
    assign sampleEdge = edgeStb && (edgeLead ^ ctrlQ.clockPhaseBit);
    assign setupEdge  = edgeStb && !(edgeLead ^ ctrlQ.clockPhaseBit)
                        && !(ctrlQ.clockPhaseBit && edgeCntQ == 4'h0);
    assign done       = edgeStb && (edgeCntQ == LAST_EDGE);
    assign inBit      = mSmpQ[2] ? misoS : mosiS;
    assign txBit      = ctrlQ.bitOrderSelect ? txShQ[0] : txShQ[7];
    assign rxNext     = ctrlQ.bitOrderSelect ? {inBit, rxShQ[7:1]}
                                             : {rxShQ[6:0], inBit};
    assign rxStb      = mSmpQ[2] || (sampleEdge && !isMaster);
    assign byteDone   = mDoneQ[2] || (done && !isMaster);

    // ----------------------------------------------------------------
    // avalon slave handshake
    // ----------------------------------------------------------------

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            waitQ <= 1'b1;
        end else if ((avsRead || avsWrite) && waitQ) begin
            waitQ <= 1'b0;
        end else begin
            waitQ <= 1'b1;
        end
    end

    // read data registered one cycle ahead of completion
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avsReadData <= 32'h0000_0000;
        end else if (avsRead && waitQ) begin
            if (avsAddress == ADDR_CONTROL) begin
                avsReadData <= {24'h00_0000, ctrlQ};
            end else if (avsAddress == ADDR_STATUS) begin
                avsReadData <= {24'h00_0000, doneFlagQ, wcolFlagQ, 5'h00, doubleSpeedQ};
            end else if (avsAddress == ADDR_DATA) begin
                avsReadData <= {24'h00_0000, rxBufQ};
            end else begin
                avsReadData <= 32'h0000_0000;
            end
        end
    end

    assign avsWaitRequest = waitQ;

    // ----------------------------------------------------------------
    // control and status registers
    // ----------------------------------------------------------------

    // control, role bit cleared by hardware on fall-back
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrlQ <= spi_port_pkg::ctrl_s'(`SPI_CONTROL_RST);
        end else begin
            if (ctrlWr) begin
                ctrlQ <= spi_port_pkg::ctrl_s'(avsWriteData[7:0]);
            end
            if (fallBack) begin
                ctrlQ.masterSelectBit <= 1'b0;
            end
        end
    end

    // double speed is the only writable status bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            doubleSpeedQ <= 1'b0;
        end else if (statWr) begin
            doubleSpeedQ <= avsWriteData[`SPI_ST_X2_POS];
        end
    end

    // status read with a flag set arms the clear by a data access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clearArmQ <= 1'b0;
        end else if (statRd) begin
            clearArmQ <= doneFlagQ || wcolFlagQ;
        end else if (dataAcc) begin
            clearArmQ <= 1'b0;
        end
    end

    // done flag, set wins over any clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            doneFlagQ <= 1'b0;
        end else if (byteDone || fallBack) begin
            doneFlagQ <= 1'b1;
        end else if ((clearArmQ && dataAcc) || irqVectorTaken) begin
            doneFlagQ <= 1'b0;
        end
    end

    // collision flag on a data write during a transfer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wcolFlagQ <= 1'b0;
        end else if (dataWr && busy) begin
            wcolFlagQ <= 1'b1;
        end else if (clearArmQ && dataAcc) begin
            wcolFlagQ <= 1'b0;
        end
    end

    // interrupt request follows flag, enable and global enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqRequest <= 1'b0;
        end else begin
            irqRequest <= ctrlQ.irqEnableBit && doneFlagQ && globalIrqEnable;
        end
    end

    // ----------------------------------------------------------------
    // master sequencer and clock generator
    // ----------------------------------------------------------------

    // a data write in master role starts the byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= spi_port_pkg::XFER_IDLE;
        end else begin
            case (stateQ)
                spi_port_pkg::XFER_IDLE: begin
                    if (dataWr && !busy && isMaster && !fallBack) begin
                        stateQ <= spi_port_pkg::XFER_SHIFT;
                    end
                end
                spi_port_pkg::XFER_SHIFT: begin
                    if (done || fallBack || !isMaster) begin
                        stateQ <= spi_port_pkg::XFER_IDLE;
                    end
                end
                default: stateQ <= spi_port_pkg::XFER_IDLE;
            endcase
        end
    end

    // half-period counter runs only while shifting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCntQ <= 6'h00;
        end else if (stateQ != spi_port_pkg::XFER_SHIFT || divTick) begin
            divCntQ <= 6'h00;
        end else begin
            divCntQ <= divCntQ + 6'h01;
        end
    end

    // sck toggles per half period and rests at the idle level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sckQ <= 1'b0;
        end else if (stateQ == spi_port_pkg::XFER_SHIFT && edgeStb) begin
            sckQ <= !sckQ;
        end else if (stateQ == spi_port_pkg::XFER_IDLE) begin
            sckQ <= ctrlQ.clockPolarityBit;
        end
    end

    // ----------------------------------------------------------------
    // shared shift datapath
    // ----------------------------------------------------------------

    // edge counter, cleared when the slave is deselected
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            edgeCntQ <= 4'h0;
        end else if (!isMaster && !slvActive) begin
            edgeCntQ <= 4'h0;
        end else if (isMaster && stateQ == spi_port_pkg::XFER_IDLE) begin
            edgeCntQ <= 4'h0;
        end else if (edgeStb) begin
            edgeCntQ <= edgeCntQ + 4'h1;
        end
    end

    // previous synchronised sck for slave edge detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sckPrevQ <= 1'b1;
        end else begin
            sckPrevQ <= sckS;
        end
    end

    // master miso crosses the pin synchroniser: each sample and the byte end
    // wait until the pin value behind that sck edge has come through
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mSmpQ  <= 3'h0;
            mDoneQ <= 3'h0;
        end else begin
            mSmpQ  <= {mSmpQ[1:0], sampleEdge && isMaster};
            mDoneQ <= {mDoneQ[1:0], done && isMaster};
        end
    end

    // cycles spent shifting one master byte, for the bound check
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shiftCycQ <= 11'h000;
        end else if (stateQ != spi_port_pkg::XFER_SHIFT) begin
            shiftCycQ <= 11'h000;
        end else if (shiftCycQ != 11'h7FF) begin
            shiftCycQ <= shiftCycQ + 11'h001;
        end
    end

    // send register, single buffered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txShQ <= `SPI_DATA_RST;
        end else if (dataWr && !busy) begin
            txShQ <= avsWriteData[7:0];
        end else if (setupEdge) begin
            txShQ <= ctrlQ.bitOrderSelect ? {1'b0, txShQ[7:1]}
                                          : {txShQ[6:0], 1'b0};
        end
    end

    // receive shifter, partial bits dropped on deselect
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxShQ <= 8'h00;
        end else if (!isMaster && !slvActive) begin
            rxShQ <= 8'h00;
        end else if (rxStb) begin
            rxShQ <= rxNext;
        end
    end

    // receive buffer holds the last complete byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxBufQ <= `SPI_DATA_RST;
        end else if (byteDone) begin
            rxBufQ <= rxStb ? rxNext : rxShQ;
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------

    // outputs and enables, all from flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinOut <= '0;
            pinOe  <= '0;
        end else begin
            pinOut.sck  <= sckQ;
            pinOut.mosi <= txBit;
            pinOut.miso <= txBit;
            pinOe.sck   <= isMaster && !fallBack && sckDirOut;
            pinOe.mosi  <= isMaster && !fallBack && mosiDirOut;
            pinOe.miso  <= slvActive && misoDirOut;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_done_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byteDone |=> doneFlagQ)
        else $error("done flag not set after byte");

    a_fallback_role: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fallBack |=> !ctrlQ.masterSelectBit && doneFlagQ ##1 !pinOe.sck)
        else $error("fall-back did not release master role");

    a_write_collision_flag_on_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (dataWr && busy) |=> wcolFlagQ && ($stable(txShQ) || $past(setupEdge)))
        else $error("collision write not flagged or data taken");

    a_clear_sequence: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clearArmQ && dataAcc && !byteDone && !fallBack) |=> !doneFlagQ && !wcolFlagQ)
        else $error("flags not cleared by status then data access");

    a_irq_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irqRequest == $past(ctrlQ.irqEnableBit && doneFlagQ && globalIrqEnable))
        else $error("interrupt request does not follow its terms");

    a_disabled_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrlQ.portEnableBit |-> !edgeStb ##1 stateQ == spi_port_pkg::XFER_IDLE)
        else $error("transfer activity while disabled");

    a_byte_bounded: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (stateQ == spi_port_pkg::XFER_SHIFT) |-> (shiftCycQ <= BYTE_CYCLES_MAX))
        else $error("master byte did not end in time");

    a_slave_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!ctrlQ.masterSelectBit && ssS) |=> edgeCntQ == 4'h0 && rxShQ == 8'h00)
        else $error("slave logic not reset on deselect");

    a_buffer_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(rxBufQ) |-> $past(byteDone))
        else $error("receive buffer changed without a finished byte");

    a_wait_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low for more than one cycle");

endmodule

`default_nettype wire

/* spi_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// far-side spi slave, answers in every mode, msb first
// ----------------------------------------------------------------
module spi_peer_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       select_n,
    input  wire logic       clock_polarity_bit,
    input  wire logic       clock_phase_bit,
    input  wire logic [7:0] txByte,
    output logic            miso,
    output logic [7:0]      rxByte
);
    logic       sckLast;
    logic [3:0] nSetup;

    // sample on one sck edge, step the output bit on the other
    always @(sck or select_n) begin
        if (select_n) begin
            nSetup = 4'h0;
        end else if (sck !== sckLast) begin
            if ((sck != clock_polarity_bit) ^ clock_phase_bit) begin
                rxByte = {rxByte[6:0], mosi};
            end else begin
                nSetup = nSetup + 4'h1;
            end
        end
        sckLast = sck;
    end

    // deselected: released line shows the inverse, not the last bit
    assign miso = select_n ? ~txByte[0] : txByte[3'h7 - nSetup[2:0] + {2'h0, clock_phase_bit}];
endmodule

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// bench for the spi port
// ----------------------------------------------------------------
module testbench;
    localparam logic [7:0] CTL = 8'hB0;
    localparam logic [7:0] STA = 8'hB4;
    localparam logic [7:0] DAT = 8'hB8;
    logic                clk_sys         = 1'b0;
    logic                rst_n           = 1'b0;
    logic [7:0]          avsAddress      = 8'h00;
    logic                avsRead         = 1'b0;
    logic                avsWrite        = 1'b0;
    logic [31:0]         avsWriteData    = 32'h0;
    logic                globalIrqEnable = 1'b0;
    logic                irqVectorTaken  = 1'b0;
    logic                ssIsOutput      = 1'b1;
    logic                slaveSelectIn_n = 1'b1;
    logic                slaveTest       = 1'b0;
    logic                misoDir         = 1'b1;
    logic                tbSck           = 1'b0;
    logic                tbMosi          = 1'b0;
    logic                peerSel_n       = 1'b1;
    logic                clock_polarity_bit            = 1'b0;
    logic                clock_phase_bit            = 1'b0;
    logic [7:0]          peerTx          = 8'h00;
    logic [31:0]         avsReadData;
    logic                avsWaitRequest;
    logic                irqRequest;
    logic                peerMiso;
    logic                sckLast;
    logic [7:0]          peerRx;
    logic [7:0]          got;
    logic [7:0]          exp;
    logic [31:0]         rd;
    logic [7:0]          div [8] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h02, 8'h08, 8'h20, 8'h40};
    int                  halfCnt = 0, halfSeen = 0, cycles = 0, failures = 0, n_compared = 0;
    spi_port_pkg::pins_s pinIn, pinOut, pinOe;

    always #5 clk_sys = ~clk_sys;

    // master tests loop the port back through the peer, slave tests drive the pins
    assign pinIn = slaveTest ? spi_port_pkg::pins_s'({tbSck, tbMosi, 1'b1})
                             : spi_port_pkg::pins_s'({pinOut.sck, pinOut.mosi, peerMiso});

    spi_master_slave_port u_dut (.clk_sys, .rst_n, .avsAddress, .avsRead, .avsWrite,
        .avsWriteData, .avsByteEnable(4'h1), .avsReadData, .avsWaitRequest,
        .globalIrqEnable, .irqVectorTaken, .irqRequest, .ssIsOutput, .mosiDirOut(1'b1),
        .misoDirOut(misoDir), .sckDirOut(1'b1), .slaveSelectIn_n, .pinIn, .pinOut, .pinOe);

    spi_peer_model u_peer (.sck(pinOut.sck), .mosi(pinOut.mosi), .select_n(peerSel_n),
        .clock_polarity_bit, .clock_phase_bit, .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));

    // measures the last sck half period and cuts a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        sckLast <= pinOut.sck;
        if (pinOut.sck !== sckLast) begin
            halfSeen <= halfCnt;
            halfCnt <= 1;
        end else begin
            halfCnt <= halfCnt + 1;
        end
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= {24'h0, d};
        do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    task automatic waitDone();
        do bus(1'b0, STA, 8'h00); while (rd[7] !== 1'b1);
    endtask

    // external master in mode 0, eight cycles per half period
    task automatic sendBits(input logic [7:0] b, input int n);
        for (int j = 0; j < n; j++) begin
            tbMosi <= b[7 - j];
            repeat (8) @(posedge clk_sys);
            tbSck <= 1'b1;
            got <= {got[6:0], pinOe.miso ? pinOut.miso : 1'b1};
            repeat (8) @(posedge clk_sys);
            tbSck <= 1'b0;
        end
        tbMosi <= ~tbMosi;
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            bus(1'b0, 8'hB0 + 8'(a * 4), 8'h00);
            check("reset or unmapped", rd, 32'h0);
        end
        bus(1'b1, DAT, 8'h55);
        repeat (40) @(posedge clk_sys);
        bus(1'b0, STA, 8'h00);
        check("disabled status", rd, 32'h0);
        $display("test reset done");
        slaveSelectIn_n <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            clock_polarity_bit <= i[0];
            clock_phase_bit <= i[1];
            peerTx <= 8'h5A + 8'(i);
            exp = 8'hC3 ^ 8'(i);
            bus(1'b1, CTL, {1'b0, 1'b1, i[2], 1'b1, i[0], i[1], i[1:0]});
            bus(1'b1, STA, {7'h00, i[2]});
            peerSel_n <= 1'b0;
            bus(1'b1, DAT, exp);
            bus(1'b1, DAT, 8'hFF);
            waitDone();
            check("status", rd, {24'h0, 2'b11, 5'h00, i[2]});
            check("sck idle", pinOut.sck, clock_polarity_bit);
            check("half period", halfSeen * 2, div[i]);
            check("peer rx", peerRx, i[2] ? 8'({<<{exp}}) : exp);
            bus(1'b0, DAT, 8'h00);
            check("data", rd, i[2] ? 8'({<<{peerTx}}) : peerTx);
            bus(1'b0, STA, 8'h00);
            check("cleared", rd, {31'h0, i[2]});
            peerSel_n <= 1'b1;
        end
        $display("test master modes done");
        ssIsOutput <= 1'b0;
        slaveSelectIn_n <= 1'b1;
        globalIrqEnable <= 1'b1;
        bus(1'b1, STA, 8'h00);
        bus(1'b1, CTL, 8'hD0);
        repeat (4) @(posedge clk_sys);
        slaveSelectIn_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("irq", irqRequest, 1'b1);
        check("sck oe", pinOe.sck, 1'b0);
        bus(1'b0, CTL, 8'h00);
        check("control", rd, 32'hC0);
        irqVectorTaken <= 1'b1;
        @(posedge clk_sys);
        irqVectorTaken <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("irq off", irqRequest, 1'b0);
        $display("test fall-back done");
        slaveSelectIn_n <= 1'b1;
        slaveTest <= 1'b1;
        bus(1'b1, CTL, 8'h43);
        bus(1'b1, DAT, 8'hA5);
        slaveSelectIn_n <= 1'b0;
        misoDir <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("miso user off", pinOe.miso, 1'b0);
        misoDir <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("miso oe", pinOe.miso, 1'b1);
        check("slave sck oe", pinOe.sck, 1'b0);
        sendBits(8'h81, 3);
        slaveSelectIn_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("miso off", pinOe.miso, 1'b0);
        bus(1'b1, DAT, 8'hA5);
        slaveSelectIn_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sendBits(8'h3C, 8);
        waitDone();
        bus(1'b0, DAT, 8'h00);
        check("slave rx", rd, 32'h3C);
        check("slave tx", got, 8'hA5);
        $display("test slave done");
        close_out();
    end
endmodule

`default_nettype wire
